/* common/adc_seq_consts.svh */
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// clock and fixed conversion counts
`define CLK_MHZ         200
`define K1_DEF          4352
`define K2_DEF          17408
`define K3_DEF          25600
`define CNT_W           15
`define RES_W           13
`define CIN_W           14

// fixed part of the data-valid wait in self-triggering mode
`define DAV_FIXED_NS    20000
`define DAV_FIXED_CYC   ((`DAV_FIXED_NS * `CLK_MHZ + 999) / 1000)

// interval of 2N at which N passes full scale by half a step
`define OVR_T5          15'h3fff
`define CIN_MAX         14'h3fff
`define N_MAX           14'h1fff
`define SETTLE_LAST     3'h4
`define POS_FS          13'h0fff
`define NEG_FS          13'h1000

// register map, byte addresses
`define ADDR_W          8
`define REG_CTRL        8'h00
`define REG_DAV         8'h04
`define REG_STATUS      8'h08
`define REG_RESULT      8'h0c
`define CTRL_AUTO_BIT   0
`define CTRL_RST        1'b0
`define DAV_RST         32'h0000_0000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* common/adc_seq_pkg.sv */
package adc_seq_pkg;

  // sequencer phases, one-hot
  typedef enum logic [9:0] {
    ST_IDLE   = 10'b00_0000_0001,
    ST_ARM    = 10'b00_0000_0010,
    ST_PH0    = 10'b00_0000_0100,
    ST_PH1    = 10'b00_0000_1000,
    ST_PH2    = 10'b00_0001_0000,
    ST_PH3    = 10'b00_0010_0000,
    ST_PH4    = 10'b00_0100_0000,
    ST_TAIL   = 10'b00_1000_0000,
    ST_SETTLE = 10'b01_0000_0000,
    ST_DAV    = 10'b10_0000_0000
  } seq_state_t;

endpackage

/* rtl/axil_reg_slave.sv */
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module axil_reg_slave
  import adc_seq_pkg::*;
(
  // clock, enable, synchronised reset
  input  wire logic                clk,
  input  wire logic                ce,
  input  wire logic                rst_s,
  // axi4-lite slave
  input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // register file side
  output logic                     wr_stb,
  output logic [`ADDR_W-1:0]       wr_addr,
  output logic [31:0]              wr_data,
  output logic [3:0]               wr_strb,
  input  wire logic                wr_ok,
  output logic [`ADDR_W-1:0]       rd_addr,
  input  wire logic [31:0]         rd_data,
  input  wire logic                rd_ok
);

  logic aw_held;
  logic w_held;

  // each channel is taken on its own, the write fires once both are held and no write response is pending
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign wr_stb        = ce & aw_held & w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_addr       = s_axi_araddr;

  // write address and data capture
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (wr_stb) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (wr_stb) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response and read answer
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= '0;
    end else if (ce) begin
      if (wr_stb) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* rtl/adc_sequencer.sv */
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int K1_COUNT = `K1_DEF,
  parameter int K2_COUNT = `K2_DEF,
  parameter int K3_COUNT = `K3_DEF
) (
  // clock, enable, reset
  input  wire logic                clk,
  input  wire logic                ce,
  input  wire logic                rst_n,
  // axi4-lite slave
  input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // conversion control and comparator
  input  wire logic                conversion_trigger,
  input  wire logic                comparator_level,
  // integrator switches
  output logic                     first_integrator_switch,
  output logic                     second_integrator_switch,
  output logic                     third_integrator_switch,
  // count pulse loop
  output logic                     count_pulse_output,
  input  wire logic                count_pulse_input,
  // three-state enables
  input  wire logic                lower_bits_output_enable,
  input  wire logic                upper_bits_output_enable,
  input  wire logic                status_output_enable,
  // three-state result and status
  output logic [`RES_W-1:0]        result_bits,
  output logic [`RES_W-1:0]        result_bits_oe,
  output logic                     conversion_active,
  output logic                     conversion_active_oe,
  output logic                     conversion_idle,
  output logic                     conversion_idle_oe,
  output logic                     out_of_range_flag,
  output logic                     out_of_range_flag_oe
);

  seq_state_t         state;
  seq_state_t         next_state;
  logic [1:0]         rst_q;
  logic               rst_s;
  logic [5:0]         pin_raw;
  logic [5:0]         sync1;
  logic [5:0]         sync2;
  logic [2:0]         edge_d;
  logic [`CNT_W-1:0]  k1_cnt;
  logic [`CNT_W-1:0]  k2_cnt;
  logic [`CNT_W-1:0]  k3_cnt;
  logic [`CNT_W-1:0]  t5_cnt;
  logic [`CIN_W-1:0]  cin_cnt;
  logic [2:0]         settle_cnt;
  logic [31:0]        dav_cnt;
  logic [31:0]        dav_reg;
  logic               ctrl_auto;
  logic               half;
  logic               neg_ovr;
  logic               wr_stb;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic [`ADDR_W-1:0] rd_addr;
  logic [31:0]        rd_data;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_s = rst_q[1];

  // pin synchronisers: trigger, comparator, count in, lower, upper, status
  assign pin_raw = {status_output_enable, upper_bits_output_enable,
                    lower_bits_output_enable, count_pulse_input,
                    comparator_level, conversion_trigger};
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
      end else if (ce) begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  // edge history of trigger, comparator and count in
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      edge_d <= 3'b000;
    end else if (ce) begin
      edge_d <= sync2[2:0];
    end
  end

  wire trig_s      = sync2[0];
  wire trig_rise   = sync2[0] & ~edge_d[0];
  wire comp_change = sync2[1] ^ edge_d[1];
  wire comp_fall   = ~sync2[1] & edge_d[1];
  wire cin_rise    = sync2[2] & ~edge_d[2];
  wire in_ph1      = (state == ST_PH1);
  wire k1_end      = in_ph1 && (k1_cnt == `CNT_W'(K1_COUNT - 1));
  wire k2_end      = (state == ST_PH3) && (k2_cnt == `CNT_W'(K2_COUNT - 1));
  wire k3_run      = (state == ST_PH3) || (state == ST_PH4) || (state == ST_TAIL);
  wire k3_end      = ((state == ST_PH4) || (state == ST_TAIL)) &&
                     (k3_cnt == `CNT_W'(K3_COUNT - 1));
  wire settle_end  = (state == ST_SETTLE) && (settle_cnt == `SETTLE_LAST);
  wire [32:0] dav_limit = 33'(dav_reg) + 33'(`DAV_FIXED_CYC - 1);
  wire dav_end     = (state == ST_DAV) && (33'(dav_cnt) >= dav_limit);
  wire pos_ovr     = (t5_cnt >= `OVR_T5) || (cin_cnt > `N_MAX);
  wire [`RES_W-1:0] mapped = {~cin_cnt[12], cin_cnt[11:0]};
  wire active_next = (next_state != ST_IDLE) && (next_state != ST_DAV);

  // phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   if (trig_s) next_state = ST_ARM;
      ST_ARM:    if (!trig_s) next_state = ST_PH0;
      ST_PH0:    if (comp_change) next_state = ST_PH1;
      ST_PH1:    if (k1_end) next_state = ST_PH2;
      ST_PH2:    if (comp_fall) next_state = ST_PH3;
      ST_PH3:    if (k2_end) next_state = ST_PH4;
      ST_PH4: begin
        if (comp_fall) next_state = ST_TAIL;
        else if (k3_end) next_state = ST_SETTLE;
      end
      ST_TAIL:   if (k3_end) next_state = ST_SETTLE;
      ST_SETTLE: if (settle_end) next_state = ctrl_auto ? ST_DAV : ST_IDLE;
      ST_DAV:    if (dav_end) next_state = ST_PH0;
      default:   next_state = ST_IDLE;
    endcase
    if (trig_rise && state != ST_IDLE) next_state = ST_ARM;
  end

  // state, switches and status flops
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      state                    <= ST_IDLE;
      first_integrator_switch  <= 1'b0;
      second_integrator_switch <= 1'b0;
      third_integrator_switch  <= 1'b0;
      conversion_active        <= 1'b0;
      conversion_idle          <= 1'b1;
    end else if (ce) begin
      state                    <= next_state;
      first_integrator_switch  <= (next_state == ST_PH1);
      second_integrator_switch <= (next_state == ST_PH0) || (next_state == ST_PH2)
                                  || (next_state == ST_PH4);
      third_integrator_switch  <= (next_state == ST_PH3);
      conversion_active        <= active_next;
      conversion_idle          <= ~active_next;
    end
  end

  // fixed counters: first and second from reset crossing, third from phase two end
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      k1_cnt <= '0;
      k2_cnt <= '0;
      k3_cnt <= '0;
    end else if (ce) begin
      k1_cnt <= in_ph1 ? k1_cnt + 1'b1 : '0;
      k2_cnt <= (state == ST_PH0) ? '0 : k2_cnt + 1'b1;
      k3_cnt <= k3_run ? k3_cnt + 1'b1 : '0;
    end
  end

  // final interval, divide by two and count pulse loop
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      t5_cnt             <= '0;
      half               <= 1'b0;
      count_pulse_output <= 1'b0;
      cin_cnt            <= '0;
      neg_ovr            <= 1'b0;
      settle_cnt         <= '0;
    end else if (ce) begin
      // interval is held through settle so the overrange test still sees it
      t5_cnt             <= (state == ST_TAIL) ? t5_cnt + 1'b1 :
                            ((k3_run || state == ST_SETTLE) ? t5_cnt : '0);
      half               <= (state == ST_TAIL) & ~half;
      count_pulse_output <= (state == ST_TAIL) & half;
      if (state == ST_PH4 && !k3_end) begin
        cin_cnt <= '0;
      end else if (cin_rise && cin_cnt != `CIN_MAX) begin
        cin_cnt <= cin_cnt + 1'b1;
      end
      if (state == ST_PH3) begin
        neg_ovr <= 1'b0;
      end else if (state == ST_PH4 && k3_end) begin
        neg_ovr <= 1'b1;
      end
      settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 1'b1 : '0;
    end
  end

  // result latch once the looped pulses have arrived
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      result_bits       <= '0;
      out_of_range_flag <= 1'b0;
    end else if (ce && settle_end) begin
      result_bits       <= neg_ovr ? `NEG_FS : (pos_ovr ? `POS_FS : mapped);
      out_of_range_flag <= neg_ovr | pos_ovr;
    end
  end

  // three-state enables follow the synchronised enable pins
  assign result_bits_oe       = {{5{sync2[4]}}, {8{sync2[3]}}};
  assign conversion_active_oe = sync2[5];
  assign conversion_idle_oe   = sync2[5];
  assign out_of_range_flag_oe = sync2[5];

  // data-valid wait counter
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      dav_cnt <= '0;
    end else if (ce) begin
      dav_cnt <= (state == ST_DAV) ? dav_cnt + 1'b1 : '0;
    end
  end

  // register decode
  wire sel_ctrl = (wr_addr == `REG_CTRL);
  wire sel_dav  = (wr_addr == `REG_DAV);
  wire wr_ok    = sel_ctrl | sel_dav;
  wire rd_ok    = (rd_addr == `REG_CTRL) || (rd_addr == `REG_DAV) ||
                  (rd_addr == `REG_STATUS) || (rd_addr == `REG_RESULT);
  assign rd_data = (rd_addr == `REG_CTRL)   ? {31'h0000_0000, ctrl_auto} :
                   (rd_addr == `REG_DAV)    ? dav_reg :
                   (rd_addr == `REG_STATUS) ? {20'h00000, state, out_of_range_flag,
                                               conversion_active} :
                   (rd_addr == `REG_RESULT) ? {19'h00000, result_bits} : 32'h0000_0000;

  // control register
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      ctrl_auto <= `CTRL_RST;
    end else if (ce && wr_stb && sel_ctrl && wr_strb[0]) begin
      ctrl_auto <= wr_data[`CTRL_AUTO_BIT];
    end
  end

  // data-valid interval register, one byte lane each
  for (genvar b = 0; b < 4; b++) begin : g_dav
    always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
        dav_reg[8*b +: 8] <= 8'(`DAV_RST >> (8*b));
      end else if (ce && wr_stb && sel_dav && wr_strb[b]) begin
        dav_reg[8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
  end

  axil_reg_slave u_bus (
    .clk           (clk),
    .ce            (ce),
    .rst_s         (rst_s),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // checks on the sequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s);

  sequence s_k3_term;
    ce && state == ST_TAIL && k3_end && !trig_rise;
  endsequence

  a_ph0_switches: assert property (state == ST_PH0 |-> second_integrator_switch &&
    !first_integrator_switch && !third_integrator_switch) else $error("reset phase switches");
  a_ph0_exit: assert property (ce && state == ST_PH0 && comp_change && !trig_rise
    |=> state == ST_PH1 && first_integrator_switch && k2_cnt == 0) else $error("phase one entry");
  a_ph1_len: assert property (ce && k1_end && !trig_rise |=> state == ST_PH2 &&
    $past(k1_cnt) == K1_COUNT - 1 && second_integrator_switch) else $error("phase one length");
  a_ph2_exit: assert property (ce && state == ST_PH2 && comp_fall && !trig_rise
    |=> third_integrator_switch && k3_cnt == 0) else $error("phase two exit");
  a_ph3_exit: assert property (ce && k2_end && !trig_rise |=> state == ST_PH4 &&
    second_integrator_switch && !third_integrator_switch) else $error("phase three exit");
  a_pulse_halved: assert property (count_pulse_output && ce |=> !count_pulse_output)
    else $error("count pulses not halved");
  a_trig_busy: assert property (ce && trig_rise |=> state == ST_ARM && conversion_active)
    else $error("trigger did not arm");
  a_status_float: assert property (!sync2[5] |-> !conversion_active_oe && !out_of_range_flag_oe)
    else $error("status drives while disabled");
  a_result_map: assert property (ce && settle_end && !trig_rise && !neg_ovr && !pos_ovr
    |=> result_bits == {~$past(cin_cnt[12]), $past(cin_cnt[11:0])} && !out_of_range_flag)
    else $error("result coding");
  a_ovr_sat: assert property (ce && settle_end && !trig_rise && neg_ovr
    |=> result_bits == `NEG_FS && out_of_range_flag) else $error("negative saturation");
  a_latch_end: assert property (s_k3_term ##1 (ce && !trig_rise)[*5]
    |=> !conversion_active) else $error("busy not cleared after third counter");

endmodule

/* verification/integ_model.sv */
`timescale 1ns/1ps

module integ_model (
  // clock and switch levels
  input  wire logic        clk,
  input  wire logic        sw1,
  input  wire logic        sw2,
  input  wire logic        sw3,
  // cycles under switch two until the crossing
  input  wire logic [15:0] ramp,
  // comparator output
  output logic             cmp
);
  logic [15:0] cnt = 16'h0000;

  initial cmp = 1'b0;

  // slope rises under switches one and three, crosses once per switch-two spell
  always @(posedge clk) begin
    cnt <= sw2 ? cnt + 16'h0001 : 16'h0000;
    if (sw1 || sw3) begin
      cmp <= 1'b1;
    end else if (sw2 && cnt == ramp) begin
      cmp <= ~cmp;
    end
  end
endmodule

/* verification/four_phase_integrating_adc_sequencer_tb.sv */
`timescale 1ns/1ps
`include "adc_seq_consts.svh"

module four_phase_integrating_adc_sequencer_tb;
  import adc_seq_pkg::*;
  localparam int K3 = 16450;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        conversion_trigger = 1'b0, comparator_level, count_pulse_output;
  logic        lower_bits_output_enable = 1'b0, upper_bits_output_enable = 1'b0;
  logic        status_output_enable = 1'b0;
  logic        first_integrator_switch, second_integrator_switch, third_integrator_switch;
  logic [12:0] result_bits, result_bits_oe;
  logic        conversion_active, conversion_active_oe, conversion_idle, conversion_idle_oe;
  logic        out_of_range_flag, out_of_range_flag_oe;
  logic [15:0] ramp = 16'd20;
  int          err_total = 0, num_checks = 0, npulse = 0, blen = 0, blen0, idle_n = 0;
  wire         count_pulse_input = count_pulse_output;
  wire [3:0]   mon = {third_integrator_switch, second_integrator_switch,
                      first_integrator_switch, conversion_active};

  always #2.5 clk = ~clk;

  adc_sequencer #(.K1_COUNT(8), .K2_COUNT(32), .K3_COUNT(K3)) dut (
    .clk, .ce, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .conversion_trigger, .comparator_level,
    .first_integrator_switch, .second_integrator_switch, .third_integrator_switch,
    .count_pulse_output, .count_pulse_input, .lower_bits_output_enable,
    .upper_bits_output_enable, .status_output_enable, .result_bits, .result_bits_oe,
    .conversion_active, .conversion_active_oe, .conversion_idle, .conversion_idle_oe,
    .out_of_range_flag, .out_of_range_flag_oe);

  integ_model model (.clk, .sw1(first_integrator_switch), .sw2(second_integrator_switch),
    .sw3(third_integrator_switch), .ramp, .cmp(comparator_level));

  // pulse, busy and idle cycle counters
  always @(posedge clk) begin
    if (count_pulse_output) npulse <= npulse + 1;
    if (conversion_active) blen <= blen + 1;
    idle_n <= conversion_active ? 0 : idle_n + 1;
  end

  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hang;
    err_total++;
    complete_run();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitbit(input int b, input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      if (mon[b] === v) return;
      @(posedge clk);
    end
    hang();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (s_axi_bvalid !== 1'b1) hang();
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (s_axi_rvalid !== 1'b1) hang();
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask

  task automatic pulse;
    conversion_trigger <= 1'b1;
    repeat (3) @(posedge clk);
    conversion_trigger <= 1'b0;
  endtask

  // {flag, code} from the looped pulse count, saturating when out of range
  function automatic logic [13:0] expect_of(input int n, input bit neg);
    if (neg) return {1'b1, `NEG_FS};
    if (n > 8191) return {1'b1, `POS_FS};
    return {1'b0, ~n[12], n[11:0]};
  endfunction

  // one conversion, optionally aborted in phase one, then result readout
  task automatic convert(input int d4, input bit neg, input bit ab);
    logic [13:0] e;
    logic [31:0] r;
    int n;
    npulse <= 0;
    blen <= 0;
    ramp <= 16'd4;
    pulse();
    waitbit(2, 1'b1, 30);
    chk(mon, 4'h5);
    waitbit(1, 1'b1, 300);
    if (ab) begin
      pulse();
      waitbit(2, 1'b1, 30);
      chk(mon, 4'h5);
      waitbit(1, 1'b1, 300);
    end
    chk(mon[3:1], 3'b001);
    n = 0;
    while (mon[1] === 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk(n, 8);
    chk(mon[3:1], 3'b010);
    waitbit(3, 1'b1, 300);
    chk(mon[3:1], 3'b100);
    ramp <= d4[15:0];
    waitbit(2, 1'b1, 300);
    chk(mon[3:1], 3'b010);
    waitbit(0, 1'b0, K3 + 300);
    e = expect_of(npulse, neg);
    axr(`REG_RESULT, r, `RESP_OKAY);
    chk(r, {19'h0, e[12:0]});
    axr(`REG_STATUS, r, `RESP_OKAY);
    chk(r[1:0], {e[13], 1'b0});
    {lower_bits_output_enable, upper_bits_output_enable, status_output_enable} <= 3'b111;
    repeat (4) @(posedge clk);
    chk({result_bits_oe, result_bits}, {13'h1fff, e[12:0]});
    chk({out_of_range_flag_oe, out_of_range_flag, conversion_idle}, {1'b1, e[13], 1'b1});
    {lower_bits_output_enable, upper_bits_output_enable, status_output_enable} <= 3'b000;
    repeat (4) @(posedge clk);
    chk({result_bits_oe, conversion_active_oe, conversion_idle_oe, out_of_range_flag_oe}, 0);
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] v;
    void'($urandom(32'h7aca));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    axr(`REG_CTRL, r, `RESP_OKAY);
    chk(r, 32'h0);
    axr(`REG_DAV, r, `RESP_OKAY);
    chk(r, `DAV_RST);
    axr(`REG_STATUS, r, `RESP_OKAY);
    chk(r, 32'h4);
    axr(8'h10, r, `RESP_SLVERR);
    chk(r, 32'h0);
    axw(`REG_RESULT, 32'h1, `RESP_SLVERR);
    v = $urandom;
    axw(`REG_DAV, v, `RESP_OKAY);
    axr(`REG_DAV, r, `RESP_OKAY);
    chk(r, v);
    axw(`REG_DAV, 32'ha, `RESP_OKAY);
    convert(2, 1'b0, 1'b0);
    blen0 = blen;
    convert(300 + $urandom % 15000, 1'b0, 1'b0);
    chk(blen, blen0);
    axw(`REG_CTRL, 32'h1, `RESP_OKAY);
    convert(20000, 1'b1, 1'b1);
    ramp <= 16'd4;
    waitbit(0, 1'b1, 4300);
    chk(idle_n >= `DAV_FIXED_CYC + 10 && idle_n <= `DAV_FIXED_CYC + 16, 1);
    complete_run();
  end
endmodule
